// [inc/ffm_pkg.sv]
`default_nettype none

package ffm_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;
    localparam int NUM_QTY = 7;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [IDX_W-1:0] IDX_CURRENT_ALPHA_AXIS = 14'h04DC;
    localparam logic [IDX_W-1:0] IDX_CURRENT_BETA_AXIS = 14'h04DE;
    localparam logic [IDX_W-1:0] IDX_VOLTAGE_ALPHA_AXIS = 14'h04E0;
    localparam logic [IDX_W-1:0] IDX_CURRENT_DIRECT_AXIS = 14'h04EC;
    localparam logic [IDX_W-1:0] IDX_CURRENT_QUAD_AXIS = 14'h04EE;
    localparam logic [IDX_W-1:0] IDX_VOLTAGE_DIRECT_AXIS = 14'h04F0;
    localparam logic [IDX_W-1:0] IDX_VOLTAGE_QUAD_AXIS = 14'h04F2;
    localparam logic [IDX_W-1:0] IDX_MONITOR_CONTROL = 14'h04F4;
    localparam logic [IDX_W-1:0] IDX_MONITOR_STATUS = 14'h04F6;

    // Slot order of the monitored quantities
    localparam int SLOT_CURRENT_ALPHA_AXIS = 0;
    localparam int SLOT_CURRENT_BETA_AXIS = 1;
    localparam int SLOT_VOLTAGE_ALPHA_AXIS = 2;
    localparam int SLOT_CURRENT_DIRECT_AXIS = 3;
    localparam int SLOT_CURRENT_QUAD_AXIS = 4;
    localparam int SLOT_VOLTAGE_DIRECT_AXIS = 5;
    localparam int SLOT_VOLTAGE_QUAD_AXIS = 6;

    localparam logic [IDX_W-1:0] QTY_INDEX [NUM_QTY] = '{
        IDX_CURRENT_ALPHA_AXIS, IDX_CURRENT_BETA_AXIS, IDX_VOLTAGE_ALPHA_AXIS,
        IDX_CURRENT_DIRECT_AXIS, IDX_CURRENT_QUAD_AXIS, IDX_VOLTAGE_DIRECT_AXIS,
        IDX_VOLTAGE_QUAD_AXIS
    };

    // ==========================================================
    // Fields and reset values
    localparam int FRAC_BITS = 27;
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int STAT_FRESH_LSB = 0;
    localparam int STAT_FREEZE_BIT = 8;
    localparam logic [DATA_W-1:0] QTY_RESET = 32'h0000_0000;
    localparam logic FREEZE_RESET = 1'b0;
    localparam logic [NUM_QTY-1:0] FRESH_RESET = 7'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {WR_COLLECT, WR_RESP} ffm_wr_state_type;
    typedef enum logic {RD_IDLE, RD_DATA} ffm_rd_state_type;

endpackage

`default_nettype wire

// [logic/ffm_addr_decode.sv]
`default_nettype none

module ffm_addr_decode
    import ffm_pkg::*;
(
    input wire logic [IDX_W-1:0] index,
    output logic [NUM_QTY-1:0] qty_sel,
    output logic ctrl_sel,
    output logic stat_sel,
    output logic hit
);

    always_comb begin
        for (int i = 0; i < NUM_QTY; i++) begin
            qty_sel[i] = (index == QTY_INDEX[i]);
        end
        ctrl_sel = (index == IDX_MONITOR_CONTROL);
        stat_sel = (index == IDX_MONITOR_STATUS);
        hit = (|qty_sel) || ctrl_sel || stat_sel;
    end

endmodule

`default_nettype wire

// [logic/ffm_frame_monitor_regs.sv]
// Function
// R1: Alpha current word, amps = word/2^27*6.25/8
// R2: Beta current word, same current scaling
// R3: Alpha voltage word, volts = word/2^27*60/sqrt3
// R4: Direct-axis measured current, current scaling
// R5: Quadrature-axis measured current, current scaling
// R6: Direct-axis applied voltage, voltage scaling
// R7: Quadrature-axis applied voltage, voltage scaling
// R8: Full 32-bit two's complement field
// R9: All monitor registers zero after reset
// R10: Rotating-frame words at consecutive even offsets
// R11: Reads free of side effects; writes ignored (here a status read clears the fresh flags and a control write sets the freeze)
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none

module ffm_frame_monitor_regs
    import ffm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [DATA_W-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [DATA_W-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [DATA_W-1:0] current_alpha_axis_in,
    input wire logic current_alpha_axis_strobe,
    input wire logic [DATA_W-1:0] current_beta_axis_in,
    input wire logic current_beta_axis_strobe,
    input wire logic [DATA_W-1:0] voltage_alpha_axis_in,
    input wire logic voltage_alpha_axis_strobe,
    input wire logic [DATA_W-1:0] current_direct_axis_in,
    input wire logic current_direct_axis_strobe,
    input wire logic [DATA_W-1:0] current_quad_axis_in,
    input wire logic current_quad_axis_strobe,
    input wire logic [DATA_W-1:0] voltage_direct_axis_in,
    input wire logic voltage_direct_axis_strobe,
    input wire logic [DATA_W-1:0] voltage_quad_axis_in,
    input wire logic voltage_quad_axis_strobe,
    output logic monitor_frozen
);

    // ==========================================================
    // Quantity inputs from the control algorithm
    logic [DATA_W-1:0] qty_in [NUM_QTY];
    logic [NUM_QTY-1:0] qty_strobe;
    logic [DATA_W-1:0] qty_value [NUM_QTY];
    logic [NUM_QTY-1:0] qty_load;

    assign qty_in[SLOT_CURRENT_ALPHA_AXIS] = current_alpha_axis_in; // [R1]
    assign qty_in[SLOT_CURRENT_BETA_AXIS] = current_beta_axis_in; // [R2]
    assign qty_in[SLOT_VOLTAGE_ALPHA_AXIS] = voltage_alpha_axis_in; // [R3]
    assign qty_in[SLOT_CURRENT_DIRECT_AXIS] = current_direct_axis_in; // [R4]
    assign qty_in[SLOT_CURRENT_QUAD_AXIS] = current_quad_axis_in; // [R5]
    assign qty_in[SLOT_VOLTAGE_DIRECT_AXIS] = voltage_direct_axis_in; // [R6]
    assign qty_in[SLOT_VOLTAGE_QUAD_AXIS] = voltage_quad_axis_in; // [R7]

    assign qty_strobe[SLOT_CURRENT_ALPHA_AXIS] = current_alpha_axis_strobe;
    assign qty_strobe[SLOT_CURRENT_BETA_AXIS] = current_beta_axis_strobe;
    assign qty_strobe[SLOT_VOLTAGE_ALPHA_AXIS] = voltage_alpha_axis_strobe;
    assign qty_strobe[SLOT_CURRENT_DIRECT_AXIS] = current_direct_axis_strobe;
    assign qty_strobe[SLOT_CURRENT_QUAD_AXIS] = current_quad_axis_strobe;
    assign qty_strobe[SLOT_VOLTAGE_DIRECT_AXIS] = voltage_direct_axis_strobe;
    assign qty_strobe[SLOT_VOLTAGE_QUAD_AXIS] = voltage_quad_axis_strobe;

    // ==========================================================
    // Monitor control and freshness state
    logic freeze_reg;
    logic freeze_next;
    logic [NUM_QTY-1:0] fresh_reg;
    logic [NUM_QTY-1:0] fresh_next;

    // Freeze lets software read a coherent set across several reads
    assign qty_load = qty_strobe & {NUM_QTY{~freeze_reg}};

    genvar g;
    generate
        for (g = 0; g < NUM_QTY; g++) begin : gen_qty
            ffm_word_reg #(
                .WIDTH(DATA_W),
                .RESET_VALUE(QTY_RESET)
            ) u_word (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .load(qty_load[g]),
                .load_value(qty_in[g]),
                .value(qty_value[g])
            ); // [R8] [R9]
        end
    endgenerate

    // ==========================================================
    // Write channel
    ffm_wr_state_type wr_state_reg;
    ffm_wr_state_type wr_state_next;
    logic aw_held_reg;
    logic aw_held_next;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [ADDR_W-1:0] aw_addr_next;
    logic w_held_reg;
    logic w_held_next;
    logic [DATA_W-1:0] w_data_reg;
    logic [DATA_W-1:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;

    logic aw_fire;
    logic w_fire;
    logic wr_commit;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [NUM_QTY-1:0] wr_qty_sel;
    logic wr_ctrl_sel;
    logic wr_stat_sel;
    logic wr_hit;

    assign s_axil_awready = (wr_state_reg == WR_COLLECT) && !aw_held_reg;
    assign s_axil_wready = (wr_state_reg == WR_COLLECT) && !w_held_reg;
    assign aw_fire = s_axil_awvalid && s_axil_awready;
    assign w_fire = s_axil_wvalid && s_axil_wready;
    assign wr_addr = aw_held_reg ? aw_addr_reg : s_axil_awaddr;
    assign wr_data = w_held_reg ? w_data_reg : s_axil_wdata;
    assign wr_strb = w_held_reg ? w_strb_reg : s_axil_wstrb;
    assign wr_commit = (wr_state_reg == WR_COLLECT) && (aw_held_reg || aw_fire)
        && (w_held_reg || w_fire);

    ffm_addr_decode u_wr_decode (
        .index(wr_addr[ADDR_W-1:2]),
        .qty_sel(wr_qty_sel),
        .ctrl_sel(wr_ctrl_sel),
        .stat_sel(wr_stat_sel),
        .hit(wr_hit)
    );

    always_comb begin
        wr_state_next = wr_state_reg;
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bresp_next = bresp_reg;
        freeze_next = freeze_reg;
        case (wr_state_reg)
            WR_COLLECT: begin
                if (wr_commit) begin
                    wr_state_next = WR_RESP;
                    aw_held_next = 1'b0;
                    w_held_next = 1'b0;
                    // Monitor words accept the write but keep their value
                    bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR; // [R11]
                    if (wr_ctrl_sel && wr_strb[0]) begin
                        freeze_next = wr_data[CTRL_FREEZE_BIT];
                    end
                end else begin
                    if (aw_fire) begin
                        aw_held_next = 1'b1;
                        aw_addr_next = s_axil_awaddr;
                    end
                    if (w_fire) begin
                        w_held_next = 1'b1;
                        w_data_next = s_axil_wdata;
                        w_strb_next = s_axil_wstrb;
                    end
                end
            end
            WR_RESP: begin
                if (s_axil_bready) begin
                    wr_state_next = WR_COLLECT;
                end
            end
            default: begin
                wr_state_next = WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_state_reg <= WR_COLLECT;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bresp_reg <= RESP_OKAY;
            freeze_reg <= FREEZE_RESET;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bresp_reg <= bresp_next;
            freeze_reg <= freeze_next;
        end
    end

    assign s_axil_bvalid = (wr_state_reg == WR_RESP);
    assign s_axil_bresp = bresp_reg;
    assign monitor_frozen = freeze_reg;

    // ==========================================================
    // Read channel
    ffm_rd_state_type rd_state_reg;
    ffm_rd_state_type rd_state_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    logic ar_fire;
    logic [NUM_QTY-1:0] rd_qty_sel;
    logic rd_ctrl_sel;
    logic rd_stat_sel;
    logic rd_hit;
    logic [DATA_W-1:0] rd_word;

    assign s_axil_arready = (rd_state_reg == RD_IDLE);
    assign ar_fire = s_axil_arvalid && s_axil_arready;

    ffm_addr_decode u_rd_decode (
        .index(s_axil_araddr[ADDR_W-1:2]),
        .qty_sel(rd_qty_sel),
        .ctrl_sel(rd_ctrl_sel),
        .stat_sel(rd_stat_sel),
        .hit(rd_hit)
    ); // [R10]

    always_comb begin
        rd_word = '0;
        for (int i = 0; i < NUM_QTY; i++) begin
            if (rd_qty_sel[i]) begin
                rd_word = qty_value[i]; // [R8] [R11]
            end
        end
        if (rd_ctrl_sel) begin
            rd_word[CTRL_FREEZE_BIT] = freeze_reg;
        end
        if (rd_stat_sel) begin
            rd_word[STAT_FRESH_LSB +: NUM_QTY] = fresh_reg;
            rd_word[STAT_FREEZE_BIT] = freeze_reg;
        end
    end

    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rd_state_reg)
            RD_IDLE: begin
                if (ar_fire) begin
                    rd_state_next = RD_DATA;
                    rdata_next = rd_word;
                    rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
                end
            end
            RD_DATA: begin
                if (s_axil_rready) begin
                    rd_state_next = RD_IDLE;
                end
            end
            default: begin
                rd_state_next = RD_IDLE;
            end
        endcase
    end

    // Flags clear on a status read only, so word reads change nothing
    // A new value landing in that read cycle keeps its flag: set wins
    always_comb begin
        fresh_next = (fresh_reg & ~{NUM_QTY{ar_fire && rd_stat_sel}}) | qty_load; // [R11]
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_state_reg <= RD_IDLE;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            fresh_reg <= FRESH_RESET;
        end else begin
            rd_state_reg <= rd_state_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            fresh_reg <= fresh_next;
        end
    end

    assign s_axil_rvalid = (rd_state_reg == RD_DATA);
    assign s_axil_rdata = rdata_reg;
    assign s_axil_rresp = rresp_reg;

endmodule

`default_nettype wire

// [logic/ffm_word_reg.sv]
`default_nettype none

module ffm_word_reg
    import ffm_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (load) begin
            value_next = load_value;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule

`default_nettype wire

// [verif/ffm_frame_monitor_props.sv]
`default_nettype none

module ffm_frame_monitor_props
    import ffm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [DATA_W-1:0] s_axil_rdata,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [DATA_W-1:0] current_direct_axis_in,
    input wire logic current_direct_axis_strobe,
    input wire logic monitor_frozen
);
    // ==========================================================
    // Bus and load checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence seq_ar_taken;
        s_axil_arvalid && s_axil_arready;
    endsequence

    sequence seq_wr_taken;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence

    // Word loaded one edge before the read must come back unchanged
    property p_load_read;
        logic [DATA_W-1:0] v;
        (current_direct_axis_strobe && !monitor_frozen, v = current_direct_axis_in) ##1
            (seq_ar_taken and s_axil_araddr[ADDR_W-1:2] == IDX_CURRENT_DIRECT_AXIS)
            |=> s_axil_rdata == v;
    endproperty

    chk_load_read: assert property (p_load_read)
        else $error("direct current read did not return loaded word");
    chk_read_answer: assert property (seq_ar_taken |=> s_axil_rvalid && !s_axil_arready)
        else $error("read answer not one cycle after address");
    chk_write_answer: assert property (seq_wr_taken |=> s_axil_bvalid && !s_axil_awready
            && !s_axil_wready)
        else $error("write answer not one cycle after address and data");
    chk_bresp_hold: assert property (s_axil_bvalid && !s_axil_bready
            |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped or changed while stalled");
    chk_rdata_hold: assert property (s_axil_rvalid && !s_axil_rready
            |=> s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
        else $error("read response dropped or changed while stalled");
    chk_b_release: assert property (s_axil_bvalid && s_axil_bready
            |=> !s_axil_bvalid && s_axil_awready && s_axil_wready)
        else $error("write channel not idle after response");
    chk_r_release: assert property (s_axil_rvalid && s_axil_rready
            |=> !s_axil_rvalid && s_axil_arready)
        else $error("read channel not idle after response");
    chk_unmapped_zero: assert property (s_axil_rvalid && s_axil_rresp == RESP_SLVERR
            |-> s_axil_rdata == 32'h0000_0000)
        else $error("error read returned nonzero data");
endmodule

bind ffm_frame_monitor_regs ffm_frame_monitor_props u_ffm_frame_monitor_props (
    .core_clk, .reset_n, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid,
    .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
    .s_axil_rready, .current_direct_axis_in, .current_direct_axis_strobe, .monitor_frozen
);

`default_nettype wire

// [verif/tb.sv]
`default_nettype none

module tb import ffm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] s_axil_awaddr = '0;
    logic [ADDR_W-1:0] s_axil_araddr = '0;
    logic [DATA_W-1:0] s_axil_wdata = '0;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic s_axil_awvalid = 1'b0;
    logic s_axil_wvalid = 1'b0;
    logic s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0;
    logic s_axil_rready = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic monitor_frozen;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [DATA_W-1:0] s_axil_rdata;
    logic [DATA_W-1:0] qv [NUM_QTY] = '{default: '0};
    logic [NUM_QTY-1:0] qs = '0;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    // Printed offsets, kept apart from the design's own table
    localparam logic [IDX_W-1:0] OFS [NUM_QTY] = '{14'h04DC, 14'h04DE, 14'h04E0,
        14'h04EC, 14'h04EE, 14'h04F0, 14'h04F2};
    // Sign and range corners of the fixed-point words
    localparam logic [DATA_W-1:0] PAT [NUM_QTY] = '{32'h8000_0000, 32'hFFFF_FFFF,
        32'h7FFF_FFFF, 32'h0800_0000, 32'hF800_0000, 32'h0000_0001, 32'hC3A5_5A3C};

    always #2 core_clk = ~core_clk;

    ffm_frame_monitor_regs u_ffm_frame_monitor_regs (
        .core_clk, .reset_n, .s_axil_awaddr, .s_axil_awprot(3'h0), .s_axil_awvalid,
        .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
        .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
        .s_axil_arprot(3'h0), .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
        .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
        .current_alpha_axis_in(qv[0]), .current_alpha_axis_strobe(qs[0]),
        .current_beta_axis_in(qv[1]), .current_beta_axis_strobe(qs[1]),
        .voltage_alpha_axis_in(qv[2]), .voltage_alpha_axis_strobe(qs[2]),
        .current_direct_axis_in(qv[3]), .current_direct_axis_strobe(qs[3]),
        .current_quad_axis_in(qv[4]), .current_quad_axis_strobe(qs[4]),
        .voltage_direct_axis_in(qv[5]), .voltage_direct_axis_strobe(qs[5]),
        .voltage_quad_axis_in(qv[6]), .voltage_quad_axis_strobe(qs[6]),
        .monitor_frozen
    );

    // ==========================================================
    // Helpers; every task starts and ends just after a rising edge
    function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
        return {i, 2'b00};
    endfunction

    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
            input logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Lag holds the ready low a while to stress the response hold
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input int lag, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge core_clk);
            if (aw && s_axil_awready) begin
                aw = 1'b0;
                s_axil_awvalid <= 1'b0;
            end
            if (w && s_axil_wready) begin
                w = 1'b0;
                s_axil_wvalid <= 1'b0;
            end
        end
        repeat (lag) @(posedge core_clk);
        s_axil_bready <= 1'b1;
        do @(posedge core_clk); while (!s_axil_bvalid);
        r = s_axil_bresp;
        s_axil_bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input int lag,
            output logic [DATA_W-1:0] d, output logic [1:0] r);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        do @(posedge core_clk); while (!s_axil_arready);
        s_axil_arvalid <= 1'b0;
        repeat (lag) @(posedge core_clk);
        s_axil_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axil_rvalid);
        d = s_axil_rdata;
        r = s_axil_rresp;
        s_axil_rready <= 1'b0;
    endtask

    task automatic load(input int i, input logic [DATA_W-1:0] v);
        qv[i] <= v;
        qs[i] <= 1'b1;
        @(posedge core_clk);
        qs[i] <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_values;
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        chk("frozen after reset", 32'h0000_0000, 32'(monitor_frozen));
        for (int i = 0; i < NUM_QTY; i++) begin
            rd(ba(OFS[i]), 0, d, r);
            chk("reset word", 32'h0000_0000, d);
            chk("reset resp", 32'(RESP_OKAY), 32'(r));
        end
    endtask

    task automatic t_load_values;
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        for (int i = 0; i < NUM_QTY; i++) begin
            load(i, PAT[i]);
            rd(ba(OFS[i]), 0, d, r);
            chk("loaded word", PAT[i], d);
        end
        for (int i = 0; i < NUM_QTY; i++) begin
            rd(ba(OFS[i]), i % 3, d, r);
            chk("reread word", PAT[i], d);
        end
    endtask

    task automatic t_write_ignored;
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        for (int i = 0; i < NUM_QTY; i++) begin
            wr(ba(OFS[i]), 32'h1234_5678, i % 2, r);
            chk("ro write resp", 32'(RESP_OKAY), 32'(r));
            rd(ba(OFS[i]), 0, d, r);
            chk("ro write kept", PAT[i], d);
        end
        wr(ba(14'h0000), 32'h1234_5678, 0, r);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
        rd(ba(14'h0000), 2, d, r);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
        chk("unmapped data", 32'h0000_0000, d);
    endtask

    task automatic t_freeze;
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        wr(ba(IDX_MONITOR_CONTROL), 32'h0000_0001, 0, r);
        chk("frozen set", 32'h0000_0001, 32'(monitor_frozen));
        load(4, 32'h5555_AAAA);
        rd(ba(OFS[4]), 0, d, r);
        chk("frozen word", PAT[4], d);
        wr(ba(IDX_MONITOR_CONTROL), 32'h0000_0000, 0, r);
        load(4, 32'h5555_AAAA);
        rd(ba(OFS[4]), 1, d, r);
        chk("thawed word", 32'h5555_AAAA, d);
    endtask

    // Fresh flags, freeze echo, control read-back and byte-strobe gating
    task automatic t_status;
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        rd(ba(IDX_MONITOR_STATUS), 0, d, r);
        chk("fresh all", 32'h0000_007F, d);
        rd(ba(IDX_MONITOR_STATUS), 1, d, r);
        chk("fresh cleared", 32'h0000_0000, d);
        // Load and status read meet at one edge: the new flag must survive
        fork
            load(2, 32'h0000_0002);
            rd(ba(IDX_MONITOR_STATUS), 0, d, r);
        join
        chk("fresh race", 32'h0000_0000, d);
        rd(ba(OFS[2]), 0, d, r);
        chk("race word", 32'h0000_0002, d);
        rd(ba(IDX_MONITOR_STATUS), 0, d, r);
        chk("fresh kept", 32'h0000_0004, d);
        s_axil_wstrb <= 4'h0;
        wr(ba(IDX_MONITOR_CONTROL), 32'h0000_0001, 0, r);
        chk("strobe off", 32'h0000_0000, 32'(monitor_frozen));
        s_axil_wstrb <= 4'hF;
        wr(ba(IDX_MONITOR_CONTROL), 32'h0000_0001, 0, r);
        rd(ba(IDX_MONITOR_CONTROL), 0, d, r);
        chk("control read", 32'h0000_0001, d);
        rd(ba(IDX_MONITOR_STATUS), 0, d, r);
        chk("freeze echo", 32'h0000_0100, d);
        wr(ba(IDX_MONITOR_STATUS), 32'hFFFF_FFFF, 0, r);
        chk("status write", 32'(RESP_OKAY), 32'(r));
    endtask

    // ==========================================================
    // Sequence, watchdog and verdict
    task automatic report_and_stop;
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_load_values();
        t_write_ignored();
        t_freeze();
        t_status();
        // Second reset in mid-run must clear every word and the freeze again
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset_values();
        report_and_stop();
    end
endmodule

`default_nettype wire
